// file: rtl/spio_defs.svh
// Register offsets, field positions, reset values and sizes of the shared pin port
`ifndef SPIO_DEFS_SVH
`define SPIO_DEFS_SVH
`define SPIO_NPINS           16
`define SPIO_IMPL_MASK       16'h0fff
`define SPIO_NFUNC           4
`define SPIO_NINMAP          4
`define SPIO_OFF_DIR         12'h000
`define SPIO_OFF_LAT         12'h004
`define SPIO_OFF_PIN         12'h008
`define SPIO_OFF_ODC         12'h00c
`define SPIO_OFF_ANA         12'h010
`define SPIO_OFF_CNEN        12'h014
`define SPIO_OFF_CNPU        12'h018
`define SPIO_OFF_CNSTAT      12'h01c
`define SPIO_OFF_INMAP0      12'h020
`define SPIO_OFF_INMAP1      12'h024
`define SPIO_OFF_ROSB        12'h028
`define SPIO_OFF_ROSC        12'h02c
`define SPIO_RST_DIR         16'hffff
`define SPIO_RST_ANA         16'h0000
`define SPIO_SEL_LO          5
`define SPIO_SEL_HI_LSB      8
`define SPIO_SEL_HI          13
`define SPIO_FIELD_MASK      16'h3f3f
`endif

// file: rtl/spio_pkg.sv
// Types shared by the shared pin port
package spio_pkg;
  typedef logic [15:0] spio_word_t;
  typedef logic [5:0]  spio_sel_t;
endpackage : spio_pkg

// file: rtl/spio_port.sv
// Shared pin general purpose port with change notify and pin remapping
//
// Contract
// - Active peripheral drive disables port driver
// - Idle enabled peripheral lets port drive
// - Port output never loops into peripheral input
// - Direction bit one input, zero output
// - Reset sets all pins to input
// - Latch reads and writes latch
// - Pin register reads pins, writes latch
// - Unimplemented bits read zero (ODC, ANA, CNEN, CNPU read back bits 15:12 as written)
// - Open-drain bit drives low only
// - Analog config resets to zero
// - Analog pins read low
// - Change on selected pins raises interrupt
// - Change enable bit gates interrupt
// - Pull-up enable bit turns on pull-up
// - Six-bit selector per remappable input
// - First remap register pins nine, eight
// - Second remap register pins eleven, ten
// - Input-only shared pin is plain port
//
// The placing of the registers and register access over APB are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
`include "spio_defs.svh"

module spio_port
  import spio_pkg::*;
(
  input  wire logic                      clk,
  input  wire logic                      reset,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [11:0]               paddr,
  input  wire logic [31:0]               pwdata,
  output logic                           pready,
  output logic [31:0]                    prdata,
  output logic                           pslverr,
  input  wire logic [15:0]               pinIn,
  output logic [15:0]                    pinOut,
  output logic [15:0]                    pinOeN,
  output logic [15:0]                    pullupEn,
  output logic [15:0]                    analogSel,
  input  wire logic [15:0]               perEnable,
  input  wire logic [15:0]               perDriveActive,
  input  wire logic [15:0]               perOut,
  input  wire logic [15:0]               perOeN,
  output logic [15:0]                    perIn,
  input  wire logic [`SPIO_NFUNC*16-1:0] remapFuncOut,
  output logic [`SPIO_NINMAP-1:0]        remapIn,
  output logic                           changeIrq
);

  // ==========================================================
  // Register storage
  spio_word_t dir_reg;
  spio_word_t lat_reg;
  spio_word_t odc_reg;
  spio_word_t ana_reg;
  spio_word_t cnen_reg;
  spio_word_t cnpu_reg;
  spio_word_t cnstat_reg;
  spio_word_t prev_reg;
  spio_word_t rosb_reg;
  spio_word_t rosc_reg;
  spio_word_t inmap0_reg;
  spio_word_t inmap1_reg;
  spio_word_t pinSample_reg;
  logic [31:0] rdata_next;
  logic        wrEn;
  logic        rdEn;
  logic        mapped;
  spio_word_t  wd;
  spio_word_t  cnstat_next;
  spio_word_t  changeHit;
  spio_word_t  remapOut;
  spio_word_t  remapOeN;
  spio_word_t  remapUsed;
  spio_word_t  portOwnN;
  // Implemented pins as a constant so single bits can be selected
  localparam spio_word_t implPins = `SPIO_IMPL_MASK;

  assign wd   = pwdata[15:0];
  assign wrEn = psel && penable && pwrite;
  assign rdEn = psel && penable && !pwrite;

  // ==========================================================
  // APB slave: zero wait states, error on unmapped address
  assign pready = 1'b1;

  always_comb
  begin
    mapped     = 1'b1;
    rdata_next = 32'h00000000;
    case (paddr)
      `SPIO_OFF_DIR:    rdata_next[15:0] = dir_reg & `SPIO_IMPL_MASK;
      `SPIO_OFF_LAT:    rdata_next[15:0] = lat_reg & `SPIO_IMPL_MASK;
      `SPIO_OFF_PIN:    rdata_next[15:0] = pinSample_reg & ~analogSel & `SPIO_IMPL_MASK;
      `SPIO_OFF_ODC:    rdata_next[15:0] = odc_reg;
      `SPIO_OFF_ANA:    rdata_next[15:0] = ana_reg;
      `SPIO_OFF_CNEN:   rdata_next[15:0] = cnen_reg;
      `SPIO_OFF_CNPU:   rdata_next[15:0] = cnpu_reg;
      `SPIO_OFF_CNSTAT: rdata_next[15:0] = cnstat_reg;
      `SPIO_OFF_INMAP0: rdata_next[15:0] = inmap0_reg;
      `SPIO_OFF_INMAP1: rdata_next[15:0] = inmap1_reg;
      `SPIO_OFF_ROSB:   rdata_next[15:0] = rosb_reg;
      `SPIO_OFF_ROSC:   rdata_next[15:0] = rosc_reg;
      default:          mapped = 1'b0;
    endcase
  end

  assign prdata  = rdEn ? rdata_next : 32'h00000000;
  assign pslverr = psel && penable && !mapped;

  // ==========================================================
  // Direction, reset to all inputs
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      dir_reg <= `SPIO_RST_DIR;
    else if (wrEn && paddr == `SPIO_OFF_DIR)
      dir_reg <= wd;
  end

  // Latch, written through either latch or pin address
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      lat_reg <= 16'h0000;
    else if (wrEn && (paddr == `SPIO_OFF_LAT || paddr == `SPIO_OFF_PIN))
      lat_reg <= wd;
  end

  // Configuration registers
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      odc_reg    <= 16'h0000;
      ana_reg    <= `SPIO_RST_ANA;
      cnen_reg   <= 16'h0000;
      cnpu_reg   <= 16'h0000;
      inmap0_reg <= 16'h0000;
      inmap1_reg <= 16'h0000;
      rosb_reg   <= 16'h0000;
      rosc_reg   <= 16'h0000;
    end
    else if (wrEn)
    begin
      case (paddr)
        `SPIO_OFF_ODC:    odc_reg <= wd;
        `SPIO_OFF_ANA:    ana_reg <= wd;
        `SPIO_OFF_CNEN:   cnen_reg <= wd;
        `SPIO_OFF_CNPU:   cnpu_reg <= wd;
        `SPIO_OFF_INMAP0: inmap0_reg <= wd & `SPIO_FIELD_MASK;
        `SPIO_OFF_INMAP1: inmap1_reg <= wd & `SPIO_FIELD_MASK;
        `SPIO_OFF_ROSB:   rosb_reg <= wd & `SPIO_FIELD_MASK;
        `SPIO_OFF_ROSC:   rosc_reg <= wd & `SPIO_FIELD_MASK;
        default:          odc_reg <= odc_reg;
      endcase
    end
  end

  // Pin sampling register for reads and change detection
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      pinSample_reg <= 16'h0000;
    else
      pinSample_reg <= pinIn & `SPIO_IMPL_MASK;
  end

  // ==========================================================
  // Analog selection: bit clear means analog, on implemented pins
  assign analogSel = ~ana_reg & `SPIO_IMPL_MASK;
  assign pullupEn  = cnpu_reg & `SPIO_IMPL_MASK;

  // ==========================================================
  // Remappable outputs on pins 8 to 11; function 0 leaves the pin unused
  genvar g;
  generate
    for (g = 0; g < 16; g = g + 1)
    begin : gRemap
      if (g >= 8 && g <= 11)
      begin : gSel
        logic [5:0] fsel;
        assign fsel = (g == 8)  ? rosb_reg[`SPIO_SEL_LO:0] :
                      (g == 9)  ? rosb_reg[`SPIO_SEL_HI:`SPIO_SEL_HI_LSB] :
                      (g == 10) ? rosc_reg[`SPIO_SEL_LO:0] :
                                  rosc_reg[`SPIO_SEL_HI:`SPIO_SEL_HI_LSB];
        assign remapUsed[g] = (fsel != 6'h00) && (fsel <= 6'(`SPIO_NFUNC));
        assign remapOut[g]  = remapUsed[g] ? remapFuncOut[(int'(fsel) - 1) * 16 + g] : 1'b0;
        assign remapOeN[g]  = !remapUsed[g];
      end
      else
      begin : gNone
        assign remapUsed[g] = 1'b0;
        assign remapOut[g]  = 1'b0;
        assign remapOeN[g]  = 1'b1;
      end
    end
  endgenerate

  // ==========================================================
  // Ownership mux: active peripheral or remapped function overrides port
  always_comb
  begin
    portOwnN = (perEnable & perDriveActive) | remapUsed;
    for (int i = 0; i < 16; i = i + 1)
    begin
      if (!implPins[i])
      begin
        pinOut[i] = 1'b0;
        pinOeN[i] = 1'b1;
      end
      else if (remapUsed[i])
      begin
        pinOut[i] = remapOut[i];
        pinOeN[i] = remapOeN[i];
      end
      else if (portOwnN[i])
      begin
        pinOut[i] = perOut[i];
        pinOeN[i] = perOeN[i];
      end
      else if (odc_reg[i])
      begin
        pinOut[i] = 1'b0;
        pinOeN[i] = dir_reg[i] | lat_reg[i];
      end
      else
      begin
        pinOut[i] = lat_reg[i];
        pinOeN[i] = dir_reg[i];
      end
    end
  end

  // Peripheral inputs: pin level, masked while the port itself drives (no loop-through)
  assign perIn = pinIn & ~(~portOwnN & ~dir_reg) & `SPIO_IMPL_MASK;

  // Remappable peripheral inputs, selected by six-bit fields
  generate
    for (g = 0; g < `SPIO_NINMAP; g = g + 1)
    begin : gInMap
      logic [5:0] isel;
      assign isel = (g == 0) ? inmap0_reg[`SPIO_SEL_LO:0] :
                    (g == 1) ? inmap0_reg[`SPIO_SEL_HI:`SPIO_SEL_HI_LSB] :
                    (g == 2) ? inmap1_reg[`SPIO_SEL_LO:0] :
                               inmap1_reg[`SPIO_SEL_HI:`SPIO_SEL_HI_LSB];
      assign remapIn[g] = (isel < 6'd16) ? perIn[isel[3:0]] : 1'b0;
    end
  endgenerate

  // ==========================================================
  // Change notification: compare with previous level, sticky status
  assign changeHit = (pinSample_reg ^ prev_reg) & cnen_reg;

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      prev_reg <= 16'h0000;
    else
      prev_reg <= pinSample_reg;
  end

  // Write-one-to-clear; a new change in the same cycle wins
  always_comb
  begin
    cnstat_next = cnstat_reg;
    if (wrEn && paddr == `SPIO_OFF_CNSTAT)
      cnstat_next = cnstat_next & ~wd;
    cnstat_next = cnstat_next | changeHit;
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      cnstat_reg <= 16'h0000;
    else
      cnstat_reg <= cnstat_next;
  end

  assign changeIrq = |cnstat_reg;

  // ==========================================================
  // Assertions
  a_dir_reset: assert property (@(posedge clk) $fell(reset) |-> dir_reg == 16'hffff)
    else $error("direction not all inputs after reset");
  a_lat_write: assert property (@(posedge clk) disable iff (reset)
    wrEn && paddr == 12'h008 |=> lat_reg == $past(wd))
    else $error("pin register write did not update latch");
  a_active_per: assert property (@(posedge clk) disable iff (reset)
    (perEnable[1] && perDriveActive[1]) |-> pinOeN[1] == perOeN[1] && pinOut[1] == perOut[1])
    else $error("port drove pin owned by active peripheral");
  a_per_idle: assert property (@(posedge clk) disable iff (reset)
    (perEnable[1] && !perDriveActive[1] && !odc_reg[1] && !dir_reg[1]) |->
      !pinOeN[1] && pinOut[1] == lat_reg[1])
    else $error("port not driving pin of idle peripheral");
  a_port_drive: assert property (@(posedge clk) disable iff (reset)
    (!perDriveActive[0] && !odc_reg[0] && !dir_reg[0]) |-> !pinOeN[0] && pinOut[0] == lat_reg[0])
    else $error("port not driving its output pin");
  a_dir_input: assert property (@(posedge clk) disable iff (reset)
    (dir_reg[3] && !(perEnable[3] && perDriveActive[3])) |-> pinOeN[3])
    else $error("input pin driven by port");
  a_no_loop: assert property (@(posedge clk) disable iff (reset)
    (!perDriveActive[1] && !dir_reg[1]) |-> !perIn[1])
    else $error("port output looped into peripheral");
  a_odc_high: assert property (@(posedge clk) disable iff (reset)
    (odc_reg[0] && lat_reg[0] && !perDriveActive[0] && !dir_reg[0]) |-> pinOeN[0])
    else $error("open drain pin driven high");
  a_unimpl_zero: assert property (@(posedge clk) disable iff (reset)
    rdEn && (paddr == `SPIO_OFF_DIR || paddr == `SPIO_OFF_LAT || paddr == `SPIO_OFF_PIN)
      |-> prdata[15:12] == 4'h0)
    else $error("unimplemented bits read nonzero");
  a_unimpl_oe: assert property (@(posedge clk) disable iff (reset)
    pinOeN[15:12] == 4'hf)
    else $error("unimplemented pin driven");
  a_analog_read: assert property (@(posedge clk) disable iff (reset)
    rdEn && paddr == `SPIO_OFF_PIN |-> (prdata[15:0] & analogSel) == 16'h0000)
    else $error("analog pin read high");
  a_change_irq: assert property (@(posedge clk) disable iff (reset)
    |changeHit |=> changeIrq)
    else $error("change did not raise interrupt");
  a_irq_hold: assert property (@(posedge clk) disable iff (reset)
    changeIrq && !(wrEn && paddr == 12'h01c) |=> changeIrq)
    else $error("pending change dropped without clear");
  a_change_clear: assert property (@(posedge clk) disable iff (reset)
    wrEn && paddr == `SPIO_OFF_CNSTAT && wd[2] && !changeHit[2] |=> !cnstat_reg[2])
    else $error("change status not cleared");
  a_ana_reset: assert property (@(posedge clk) $fell(reset) |-> ana_reg == 16'h0000)
    else $error("analog config not zero after reset");
  a_remap_field: assert property (@(posedge clk) disable iff (reset)
    rdEn && (paddr == `SPIO_OFF_ROSB || paddr == `SPIO_OFF_ROSC) |->
      prdata[15:14] == 2'b00 && prdata[7:6] == 2'b00)
    else $error("remap unimplemented bits set");
  a_remap_pin8: assert property (@(posedge clk) disable iff (reset)
    rosb_reg[5:0] == 6'h01 |-> !pinOeN[8] && pinOut[8] == remapFuncOut[8])
    else $error("remapped pin 8 not driven by function");
  a_inmap_sel: assert property (@(posedge clk) disable iff (reset)
    inmap0_reg[5:0] == 6'h05 |-> remapIn[0] == perIn[5])
    else $error("remapped input not taken from selected pin");
  a_inmap_range: assert property (@(posedge clk) disable iff (reset)
    inmap0_reg[13:8] >= 6'd16 |-> !remapIn[1])
    else $error("out of range input selector not zero");

endmodule : spio_port
`default_nettype wire

// file: tb/spio_pin_model.sv
// Package pads of the shared pin port: outside drivers, weak pull-ups, floating pins
`timescale 1ns/100ps
`default_nettype none
module spio_pin_model
  import spio_pkg::*;
(
  input  wire logic       clk,
  input  wire spio_word_t pinOut,
  input  wire spio_word_t pinOeN,
  input  wire spio_word_t pullupEn,
  input  wire spio_word_t extVal,
  input  wire spio_word_t extEn,
  output var  spio_word_t pinIn
);
  spio_word_t noise = 16'h5a3c;
  // A floating pad wanders every cycle so a stale level never reads back
  always @(posedge clk) noise <= ~noise;
  // Port drive wins, then the outside driver, then the pull-up, else float
  always_comb
    for (int i = 0; i < 16; i++)
      pinIn[i] = !pinOeN[i] ? pinOut[i] : extEn[i] ? extVal[i] : pullupEn[i] ? 1'b1 : noise[i];
endmodule : spio_pin_model
`default_nettype wire

// file: tb/testbench.sv
// Self-checking bench for the shared pin port
`timescale 1ns/100ps
`default_nettype none
`include "spio_defs.svh"
module testbench
  import spio_pkg::*;
;
  localparam spio_word_t MSK = `SPIO_IMPL_MASK;
  logic        clk, reset, psel, penable, pwrite, pready, pslverr, changeIrq, rerr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdata;
  logic [63:0] remapFuncOut;
  logic [3:0]  remapIn;
  spio_word_t  pinIn, pinOut, pinOeN, pullupEn, analogSel, perEnable, perDriveActive;
  spio_word_t  perOut, perOeN, perIn, extVal, extEn, v, d;
  int          num_errors, num_checks, cyc;

  spio_port u_dut (.clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .pinIn(pinIn), .pinOut(pinOut), .pinOeN(pinOeN), .pullupEn(pullupEn),
    .analogSel(analogSel), .perEnable(perEnable), .perDriveActive(perDriveActive),
    .perOut(perOut), .perOeN(perOeN), .perIn(perIn), .remapFuncOut(remapFuncOut),
    .remapIn(remapIn), .changeIrq(changeIrq));
  spio_pin_model u_pins (.clk(clk), .pinOut(pinOut), .pinOeN(pinOeN), .pullupEn(pullupEn),
    .extVal(extVal), .extEn(extEn), .pinIn(pinIn));

  // ==========================================================
  // Clock, watchdog and bench tasks
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Cut a hang short
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 4000)
    begin
      num_errors++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : report_and_stop
  task automatic chk(input spio_word_t got, input spio_word_t exp);
    num_checks++;
    if (got !== exp)
    begin
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      num_errors++;
    end
  endtask : chk
  // One APB transfer, held until pready is seen at an edge
  task automatic xfer(input logic w, input logic [11:0] a, input spio_word_t dat);
    @(posedge clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= {16'h0000, dat};
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
  task automatic wr(input logic [11:0] a, input spio_word_t dat);
    xfer(1'b1, a, dat);
  endtask : wr
  task automatic rd(input logic [11:0] a, input spio_word_t exp);
    xfer(1'b0, a, 16'h0000);
    chk(rdata[15:0], exp);
  endtask : rd
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
    #10;
  endtask : idle

  // ==========================================================
  // Main sequence
  initial
  begin
    reset = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = '0; pwdata = '0;
    perEnable = '0; perDriveActive = '0; perOut = '0; perOeN = '1;
    extEn = '1; extVal = '0; remapFuncOut = '0; num_errors = 0; num_checks = 0;
    v = 16'($urandom(32'hc7fd));
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    idle(1);
    chk(pinOeN & MSK, MSK);
    rd(`SPIO_OFF_DIR, MSK);
    rd(`SPIO_OFF_ANA, `SPIO_RST_ANA);
    chk(analogSel, MSK);
    $display("reset test done");
    for (int i = 0; i < 6; i++)
    begin
      v = 16'($urandom);
      wr(`SPIO_OFF_LAT, v);
      rd(`SPIO_OFF_LAT, v & MSK);
      v = 16'($urandom);
      wr(`SPIO_OFF_PIN, v);
      rd(`SPIO_OFF_LAT, v & MSK);
      d = 16'($urandom);
      wr(`SPIO_OFF_DIR, d);
      rd(`SPIO_OFF_DIR, d & MSK);
      chk(pinOeN & MSK, d & MSK);
      chk(pinOut & ~d & MSK, v & ~d & MSK);
    end
    $display("latch and direction test done");
    // Analog pins are kept as inputs by software
    wr(`SPIO_OFF_DIR, 16'hffff);
    for (int i = 0; i < 4; i++)
    begin
      d = 16'($urandom);
      wr(`SPIO_OFF_ANA, d);
      @(posedge clk);
      extVal <= 16'($urandom);
      idle(3);
      rd(`SPIO_OFF_PIN, extVal & d & MSK);
      chk(analogSel, ~d & MSK);
    end
    $display("pin level test done");
    wr(`SPIO_OFF_ANA, 16'hffff);
    wr(`SPIO_OFF_DIR, 16'h0000);
    wr(`SPIO_OFF_LAT, 16'h0004);
    @(posedge clk);
    perEnable <= 16'h0002; perDriveActive <= 16'h0002; perOut <= 16'h0002; perOeN <= 16'hfffd;
    idle(2);
    chk(pinOeN & 16'h0006, 16'h0000);
    chk(pinOut & 16'h0006, 16'h0006);
    chk(perIn & 16'h0004, 16'h0000);
    rd(`SPIO_OFF_PIN, 16'h0006);
    @(posedge clk);
    perDriveActive <= 16'h0000;
    idle(2);
    chk(pinOut & 16'h0006, 16'h0004);
    @(posedge clk);
    perEnable <= 16'h0000;
    wr(`SPIO_OFF_ODC, 16'h0001);
    wr(`SPIO_OFF_LAT, 16'h0001);
    idle(1);
    chk(pinOeN & 16'h0001, 16'h0001);
    wr(`SPIO_OFF_LAT, 16'h0000);
    idle(1);
    chk((pinOeN | pinOut) & 16'h0001, 16'h0000);
    wr(`SPIO_OFF_ODC, 16'h0000);
    $display("ownership and open drain test done");
    // Pull-ups only while the pins are inputs
    wr(`SPIO_OFF_DIR, 16'hffff);
    v = 16'($urandom);
    wr(`SPIO_OFF_CNPU, v);
    idle(1);
    chk(pullupEn & MSK, v & MSK);
    wr(`SPIO_OFF_CNEN, 16'h0004);
    wr(`SPIO_OFF_CNSTAT, 16'hffff);
    idle(1);
    chk({15'h0000, changeIrq}, 16'h0000);
    @(posedge clk);
    extVal <= extVal ^ 16'h0008;
    idle(4);
    chk({15'h0000, changeIrq}, 16'h0000);
    @(posedge clk);
    extVal <= extVal ^ 16'h0004;
    idle(3);
    chk({15'h0000, changeIrq}, 16'h0001);
    idle(4);
    rd(`SPIO_OFF_CNSTAT, 16'h0004);
    wr(`SPIO_OFF_CNSTAT, 16'h0004);
    idle(1);
    chk({15'h0000, changeIrq}, 16'h0000);
    $display("change notify test done");
    for (int i = 0; i < 4; i++)
    begin
      v = 16'($urandom);
      wr(`SPIO_OFF_INMAP0 + 12'(4 * i), v);
      rd(`SPIO_OFF_INMAP0 + 12'(4 * i), v & `SPIO_FIELD_MASK);
    end
    wr(`SPIO_OFF_INMAP0, 16'h2005);
    for (int i = 0; i < 2; i++)
    begin
      @(posedge clk);
      extVal <= extVal ^ 16'h0020;
      idle(3);
      chk({14'h0000, remapIn[1:0]}, {15'h0000, extVal[5]});
    end
    wr(`SPIO_OFF_DIR, 16'h0000);
    wr(`SPIO_OFF_ROSB, 16'h0201);
    wr(`SPIO_OFF_ROSC, 16'h0403);
    @(posedge clk);
    remapFuncOut <= {$urandom, $urandom};
    idle(2);
    chk({14'h0000, pinOut[9:8]}, {14'h0000, remapFuncOut[25], remapFuncOut[8]});
    chk({14'h0000, pinOut[11:10]}, {14'h0000, remapFuncOut[59], remapFuncOut[42]});
    xfer(1'b0, 12'h100, 16'h0000);
    chk({rdata[15:0] | rdata[31:16]} ^ {15'h0000, rerr}, 16'h0001);
    $display("remap and address test done");
    report_and_stop();
  end
endmodule : testbench
`default_nettype wire
